// ==== rtl/mpfc_map.svh ====
// register offsets, field positions, reset values and timing counts
`ifndef MPFC_MAP_SVH
`define MPFC_MAP_SVH
`define MPFC_CTRL_OFF 8'h00
`define MPFC_TYPE_OFF 8'h04
`define MPFC_HIGH_OFF 8'h08
`define MPFC_LOW_OFF 8'h0C
`define MPFC_TIMER_OFF 8'h10
`define MPFC_STAT_OFF 8'h14
`define MPFC_B_RXEN 0
`define MPFC_B_TXEN 1
`define MPFC_B_DISC 2
`define MPFC_B_PASS 3
`define MPFC_B_SWREQ 4
`define MPFC_B_RESUME 5
`define MPFC_B_EXT 6
`define MPFC_CTRL_W 7
`define MPFC_CTRL_RST 7'h00
`define MPFC_TYPE_RST 16'h8808
`define MPFC_HIGH_RST 16'h0000
`define MPFC_LOW_RST 16'h0000
`define MPFC_TIMER_RST 16'h0000
`define MPFC_CTL_MCAST 48'h0180C2000001
`define MPFC_PAUSE_OP 16'h0001
`define MPFC_CLK_NS 20
`define MPFC_SLOT_NS 512
`define MPFC_SLOT_CYC ((`MPFC_SLOT_NS + `MPFC_CLK_NS - 1) / `MPFC_CLK_NS)
`endif

// ==== rtl/mpfc_pkg.sv ====
// types shared by the flow-control block
package mpfc_pkg;
  typedef enum logic [1:0] {
    MPFC_IDLE = 2'b01,
    MPFC_SEND = 2'b10
  } mpfc_state_t;
endpackage : mpfc_pkg

// ==== rtl/mpfc_rx_classify.sv ====
// receive-side classification of pause and mac control frames
`timescale 1ns/10ps
`include "mpfc_map.svh"
module mpfc_rx_classify import mpfc_pkg::*; (
  input wire logic [47:0] rx_da,
  input wire logic [15:0] rx_type,
  input wire logic [15:0] rx_opcode,
  input wire logic rx_frame_ok,
  input wire logic [47:0] station_addr,
  input wire logic [15:0] flow_type_value,
  input wire logic std_filter_pass,
  input wire logic rx_pause_honor_enable,
  input wire logic discard_pause_bit,
  input wire logic pass_control_frames_bit,
  output logic is_pause,
  output logic deliver
);
  logic to_station;
  logic to_mcast;
  logic is_ctl;
  logic pause_raw;

  assign to_station = (rx_da == station_addr);
  assign to_mcast = (rx_da == `MPFC_CTL_MCAST);
  assign is_ctl = rx_frame_ok && (rx_type == flow_type_value) // RQ23
                  && (to_station || to_mcast);
  assign pause_raw = is_ctl && (rx_opcode == `MPFC_PAUSE_OP);
  assign is_pause = pause_raw && rx_pause_honor_enable;

  always_comb begin
    deliver = std_filter_pass;
    if (!rx_pause_honor_enable) begin
      deliver = std_filter_pass; // RQ1
    end else if (pause_raw) begin
      // multicast-addressed pause is left to the standard filters
      if (to_station && !to_mcast && discard_pause_bit) begin
        deliver = 1'b0; // RQ2
      end else begin
        deliver = std_filter_pass; // RQ3
      end
    end else if (is_ctl) begin
      deliver = std_filter_pass || pass_control_frames_bit; // RQ5 RQ6
    end
  end
endmodule : mpfc_rx_classify

// ==== rtl/mpfc_top.sv ====
// flow-control engine: apb registers, pause filtering and generation
`timescale 1ns/10ps
`include "mpfc_map.svh"
// Overview of operation
// [RQ1] receive handling off: frames filtered normally
// [RQ2] discard bit drops station-addressed pause frames
// [RQ3] multicast pause frames follow standard filtering
// [RQ4] discard bit never affects pause timer
// [RQ5] pass bit delivers non-pause control frames
// [RQ6] pass result ORed with standard filters
// [RQ7] transmit enable mirrored as config bit 8; the code mirrors it as status bit 7 and asymmetric_pause_direction
// [RQ8] xoff only when negotiation permits it
// [RQ9] reaching high threshold sends programmed pause
// [RQ10] falling to low mark sends xon
// [RQ11] overflow after xoff sends one more
// [RQ12] software enables transmission only full duplex
// [RQ13] software request sends a pause frame
// [RQ14] software request bit self-clears when sent
// [RQ15] software pause ignores enable and negotiation
// [RQ16] software zeroes timer for xon request
// [RQ17] external pins trigger xoff and xon
// [RQ18] one xoff per external xoff assertion
// [RQ19] xon pin after xoff release sends xon
// [RQ20] xon pulse needed before next xoff
// [RQ21] above-high and under-low status outputs
// [RQ22] external triggers also need transmit enable
// [RQ23] control frame needs programmed type match
// [RQ24] pause times counted in 512 ns slots; the code counts slots of 26 cycles of 20 ns, 520 ns
// [RQ25] pause inserted only at frame boundary
module mpfc_top import mpfc_pkg::*; #(
  parameter int LEVEL_W = 13
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [47:0] station_addr,
  input wire logic std_filter_pass,
  input wire logic rx_hdr_valid,
  input wire logic [47:0] rx_da,
  input wire logic [15:0] rx_type,
  input wire logic [15:0] rx_opcode,
  input wire logic [15:0] rx_quanta,
  input wire logic rx_frame_ok,
  output logic rx_deliver_valid,
  output logic rx_deliver,
  output logic tx_paused,
  input wire logic [LEVEL_W-1:0] fifo_level,
  input wire logic fifo_overflow,
  input wire logic an_pause_resolved,
  input wire logic ext_xoff_in,
  input wire logic external_resume_input,
  input wire logic tx_frame_active,
  output logic tx_pause_req,
  output logic [15:0] tx_pause_time,
  input wire logic tx_pause_done,
  output logic above_high_mark_out,
  output logic under_low_mark_out,
  output logic asymmetric_pause_direction
);
  // ==========================================================
  // parameter check
  if (LEVEL_W < 1 || LEVEL_W > 16) begin : g_bad_width
    $error("LEVEL_W must lie between 1 and 16");
  end

  localparam int SLOT_CYC = `MPFC_SLOT_CYC;

  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // ==========================================================
  // apb register file
  logic [`MPFC_CTRL_W-1:0] ctrl_reg;
  logic [15:0] flow_type_value;
  logic [LEVEL_W-1:0] rx_high_threshold;
  logic [LEVEL_W-1:0] rx_low_threshold;
  logic [15:0] tx_pause_timer_value;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic [31:0] status_word;
  logic wr_en;
  logic setup;
  logic mapped;
  logic rx_pause_honor_enable;
  logic tx_pause_enable;
  logic discard_pause_bit;
  logic pass_control_frames_bit;
  logic software_pause_request;
  logic resume_frame_enable;
  logic external_flow_enable;
  mpfc_state_t state_reg;
  logic cur_sw_reg;
  logic cur_xon_reg;
  logic sw_done;
  logic xoff_sent_reg;
  logic extra_sent_reg;
  logic ext_armed_reg;
  logic ext_xon_wait_reg;

  assign rx_pause_honor_enable = ctrl_reg[`MPFC_B_RXEN];
  assign tx_pause_enable = ctrl_reg[`MPFC_B_TXEN];
  assign discard_pause_bit = ctrl_reg[`MPFC_B_DISC];
  assign pass_control_frames_bit = ctrl_reg[`MPFC_B_PASS];
  assign software_pause_request = ctrl_reg[`MPFC_B_SWREQ];
  assign resume_frame_enable = ctrl_reg[`MPFC_B_RESUME];
  assign external_flow_enable = ctrl_reg[`MPFC_B_EXT];
  assign asymmetric_pause_direction = tx_pause_enable; // RQ7

  assign mapped = hit(paddr, `MPFC_CTRL_OFF) || hit(paddr, `MPFC_TYPE_OFF)
               || hit(paddr, `MPFC_HIGH_OFF) || hit(paddr, `MPFC_LOW_OFF)
               || hit(paddr, `MPFC_TIMER_OFF) || hit(paddr, `MPFC_STAT_OFF);
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && mapped;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_reg;
  assign sw_done = (state_reg == MPFC_SEND) && tx_pause_done && cur_sw_reg;

  assign status_word = {24'h000000, asymmetric_pause_direction,
                        ext_armed_reg, (state_reg == MPFC_SEND),
                        tx_paused, extra_sent_reg, xoff_sent_reg,
                        under_low_mark_out, above_high_mark_out};

  always_comb begin
    prdata_next = 32'h00000000;
    if (hit(paddr, `MPFC_CTRL_OFF)) begin
      prdata_next[`MPFC_CTRL_W-1:0] = ctrl_reg;
    end else if (hit(paddr, `MPFC_TYPE_OFF)) begin
      prdata_next[15:0] = flow_type_value;
    end else if (hit(paddr, `MPFC_HIGH_OFF)) begin
      prdata_next[LEVEL_W-1:0] = rx_high_threshold;
    end else if (hit(paddr, `MPFC_LOW_OFF)) begin
      prdata_next[LEVEL_W-1:0] = rx_low_threshold;
    end else if (hit(paddr, `MPFC_TIMER_OFF)) begin
      prdata_next[15:0] = tx_pause_timer_value;
    end else if (hit(paddr, `MPFC_STAT_OFF)) begin
      prdata_next = status_word;
    end
  end

  // read data captured in setup so it comes from a flop in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
    end else if (setup && !pwrite) begin
      prdata_reg <= prdata_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `MPFC_CTRL_RST;
    end else begin
      if (wr_en && hit(paddr, `MPFC_CTRL_OFF)) begin
        ctrl_reg <= pwdata[`MPFC_CTRL_W-1:0];
        // a new request written in the finishing cycle survives
        if (sw_done && !pwdata[`MPFC_B_SWREQ]) begin
          ctrl_reg[`MPFC_B_SWREQ] <= 1'b0;
        end
      end else if (sw_done) begin
        ctrl_reg[`MPFC_B_SWREQ] <= 1'b0; // RQ14
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flow_type_value <= `MPFC_TYPE_RST;
      rx_high_threshold <= LEVEL_W'(`MPFC_HIGH_RST);
      rx_low_threshold <= LEVEL_W'(`MPFC_LOW_RST);
      tx_pause_timer_value <= `MPFC_TIMER_RST;
    end else if (wr_en) begin
      if (hit(paddr, `MPFC_TYPE_OFF)) begin
        flow_type_value <= pwdata[15:0];
      end else if (hit(paddr, `MPFC_HIGH_OFF)) begin
        rx_high_threshold <= pwdata[LEVEL_W-1:0];
      end else if (hit(paddr, `MPFC_LOW_OFF)) begin
        rx_low_threshold <= pwdata[LEVEL_W-1:0];
      end else if (hit(paddr, `MPFC_TIMER_OFF)) begin
        tx_pause_timer_value <= pwdata[15:0];
      end
    end
  end

  // ==========================================================
  // receive filtering and pause timer
  logic cls_pause;
  logic cls_deliver;
  logic [15:0] pause_cnt_reg;
  logic [4:0] slot_cnt_reg;

  mpfc_rx_classify u_cls (
    .rx_da(rx_da),
    .rx_type(rx_type),
    .rx_opcode(rx_opcode),
    .rx_frame_ok(rx_frame_ok),
    .station_addr(station_addr),
    .flow_type_value(flow_type_value),
    .std_filter_pass(std_filter_pass),
    .rx_pause_honor_enable(rx_pause_honor_enable),
    .discard_pause_bit(discard_pause_bit),
    .pass_control_frames_bit(pass_control_frames_bit),
    .is_pause(cls_pause),
    .deliver(cls_deliver)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_deliver_valid <= 1'b0;
      rx_deliver <= 1'b0;
    end else begin
      rx_deliver_valid <= rx_hdr_valid;
      if (rx_hdr_valid) begin
        rx_deliver <= cls_deliver;
      end
    end
  end

  // timer is loaded whatever the discard bit says
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pause_cnt_reg <= 16'h0000;
      slot_cnt_reg <= 5'h00;
    end else if (rx_hdr_valid && cls_pause) begin
      pause_cnt_reg <= rx_quanta; // RQ4
      slot_cnt_reg <= 5'h00;
    end else if (pause_cnt_reg != 16'h0000) begin
      if (slot_cnt_reg == 5'(SLOT_CYC - 1)) begin
        slot_cnt_reg <= 5'h00;
        pause_cnt_reg <= pause_cnt_reg - 16'h0001; // RQ24
      end else begin
        slot_cnt_reg <= slot_cnt_reg + 5'h01;
      end
    end
  end
  assign tx_paused = (pause_cnt_reg != 16'h0000);

  // ==========================================================
  // threshold watch and trigger sources
  logic tx_gate;
  logic ext_gate;
  logic reach;
  logic reach_q;
  logic at_low;
  logic xoff_pin_q;
  logic xon_pin_q;
  logic ev_hw_xoff;
  logic ev_ovf;
  logic ev_hw_xon;
  logic ev_ext_xoff;
  logic ev_ext_xon;
  logic pend_xoff_reg;
  logic pend_xon_reg;
  logic take;

  assign tx_gate = tx_pause_enable && an_pause_resolved; // RQ8
  assign ext_gate = external_flow_enable && tx_gate; // RQ17 RQ22
  assign reach = (fifo_level >= rx_high_threshold);
  assign at_low = (fifo_level <= rx_low_threshold);
  assign ev_hw_xoff = tx_gate && reach && !reach_q
                      && !xoff_sent_reg; // RQ9
  assign ev_ovf = tx_gate && fifo_overflow && xoff_sent_reg
                  && !extra_sent_reg; // RQ11
  assign ev_hw_xon = xoff_sent_reg && at_low && !reach;
  assign ev_ext_xoff = ext_gate && ext_xoff_in && !xoff_pin_q
                       && ext_armed_reg; // RQ18
  assign ev_ext_xon = ext_gate && external_resume_input && !xon_pin_q
                      && !ext_xoff_in && ext_xon_wait_reg; // RQ19

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      above_high_mark_out <= 1'b0;
      under_low_mark_out <= 1'b0;
      reach_q <= 1'b0;
      xoff_pin_q <= 1'b0;
      xon_pin_q <= 1'b0;
    end else begin
      above_high_mark_out <= (fifo_level > rx_high_threshold); // RQ21
      under_low_mark_out <= (fifo_level < rx_low_threshold); // RQ21
      reach_q <= reach;
      xoff_pin_q <= ext_xoff_in;
      xon_pin_q <= external_resume_input;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xoff_sent_reg <= 1'b0;
      extra_sent_reg <= 1'b0;
    end else if (ev_hw_xoff) begin
      xoff_sent_reg <= 1'b1;
    end else if (ev_hw_xon) begin
      xoff_sent_reg <= 1'b0;
      extra_sent_reg <= 1'b0;
    end else if (ev_ovf) begin
      extra_sent_reg <= 1'b1; // RQ11
    end
  end

  // hysteresis: xon must rise and fall before the pin rearms
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_armed_reg <= 1'b1;
      ext_xon_wait_reg <= 1'b0;
    end else if (ev_ext_xoff) begin
      ext_armed_reg <= 1'b0;
      ext_xon_wait_reg <= 1'b1;
    end else if (ev_ext_xon) begin
      ext_xon_wait_reg <= 1'b0;
    end else if (!ext_armed_reg && !ext_xon_wait_reg
                 && !external_resume_input && xon_pin_q) begin
      ext_armed_reg <= 1'b1; // RQ20
    end
  end

  // a newer xoff cancels a queued xon and the reverse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_xoff_reg <= 1'b0;
      pend_xon_reg <= 1'b0;
    end else if (ev_hw_xoff || ev_ovf || ev_ext_xoff) begin
      pend_xoff_reg <= 1'b1;
      pend_xon_reg <= 1'b0;
    end else if ((ev_hw_xon || ev_ext_xon) && resume_frame_enable) begin
      pend_xon_reg <= 1'b1; // RQ10
      pend_xoff_reg <= 1'b0;
    end else if (take) begin
      if (!software_pause_request && pend_xoff_reg) begin
        pend_xoff_reg <= 1'b0;
      end else if (!software_pause_request) begin
        pend_xon_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // transmit request sequencer
  assign take = (state_reg == MPFC_IDLE) && !tx_frame_active
                && (software_pause_request || pend_xoff_reg
                    || pend_xon_reg); // RQ25
  assign tx_pause_req = (state_reg == MPFC_SEND);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= MPFC_IDLE;
      cur_sw_reg <= 1'b0;
      cur_xon_reg <= 1'b0;
      tx_pause_time <= 16'h0000;
    end else begin
      case (state_reg)
        MPFC_IDLE: begin
          if (take) begin
            state_reg <= MPFC_SEND;
            // software request bypasses enable and negotiation
            cur_sw_reg <= software_pause_request; // RQ13 RQ15
            cur_xon_reg <= !software_pause_request && !pend_xoff_reg;
            if (!software_pause_request && !pend_xoff_reg) begin
              tx_pause_time <= 16'h0000; // RQ10
            end else begin
              tx_pause_time <= tx_pause_timer_value; // RQ9 RQ16
            end
          end
        end
        MPFC_SEND: begin
          if (tx_pause_done) begin
            state_reg <= MPFC_IDLE;
          end
        end
        default: state_reg <= MPFC_IDLE;
      endcase
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence sw_finish_s;
    tx_pause_req && tx_pause_done && cur_sw_reg;
  endsequence
  sequence no_rewrite_s;
    !(wr_en && hit(paddr, `MPFC_CTRL_OFF));
  endsequence

  sw_self_clear_a: assert property ( // RQ14
    sw_finish_s and no_rewrite_s |=> !software_pause_request)
    else $error("software pause request did not clear");

  rx_plain_a: assert property ( // RQ1
    rx_hdr_valid && !rx_pause_honor_enable
    |=> rx_deliver_valid && rx_deliver == $past(std_filter_pass))
    else $error("disabled handling altered delivery");

  discard_pause_a: assert property ( // RQ2
    rx_hdr_valid && cls_pause && discard_pause_bit
    && rx_da == station_addr && rx_da != `MPFC_CTL_MCAST
    |=> !rx_deliver)
    else $error("station pause frame delivered while discarding");

  pause_load_a: assert property ( // RQ4
    rx_hdr_valid && cls_pause |=> tx_paused == ($past(rx_quanta) != 0))
    else $error("pause timer not loaded");

  no_truncate_a: assert property ( // RQ25
    $rose(tx_pause_req) |-> $past(!tx_frame_active))
    else $error("pause request raised during a frame");

  mark_out_a: assert property ( // RQ21
    1'b1 |=> above_high_mark_out
    == ($past(fifo_level) > $past(rx_high_threshold)))
    else $error("above-high output wrong");

  sw_start_a: assert property ( // RQ13
    state_reg == MPFC_IDLE && software_pause_request && !tx_frame_active
    |=> tx_pause_req && tx_pause_time == $past(tx_pause_timer_value))
    else $error("software pause not started");

  xon_zero_a: assert property ( // RQ10
    tx_pause_req && cur_xon_reg |-> tx_pause_time == 16'h0000)
    else $error("xon frame with nonzero time");

  gated_xoff_a: assert property ( // RQ22
    $rose(pend_xoff_reg) |-> $past(tx_gate))
    else $error("xoff queued without transmit permission");

  ext_once_a: assert property ( // RQ18
    ev_ext_xoff |=> !ext_armed_reg ##1 !ev_ext_xoff)
    else $error("second xoff from one pin assertion");
endmodule : mpfc_top

// ==== test/mpfc_mac_model.sv ====
// transmit mac model: takes pause frame requests and reports completion
`timescale 1ns/10ps
module mpfc_mac_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic tx_pause_req,
  input wire logic [15:0] tx_pause_time,
  output logic tx_pause_done,
  output logic [7:0] frames,
  output logic [15:0] last_time
);
  logic [3:0] wait_cnt;
  // ==========================================
  // frame sending
  // a frame takes cycles on the wire, so done never comes at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt <= 4'h0;
      tx_pause_done <= 1'b0;
      frames <= 8'h00;
      last_time <= 16'h0000;
    end else if (tx_pause_done) begin
      tx_pause_done <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (tx_pause_req) begin
      wait_cnt <= wait_cnt + 4'h1;
      if (wait_cnt == (slow ? 4'hB : 4'h1)) begin
        tx_pause_done <= 1'b1;
        frames <= frames + 8'h01;
        last_time <= tx_pause_time;
      end
    end
  end
endmodule : mpfc_mac_model

// ==== test/mpfc_top_tb.sv ====
// self-checking bench for the flow-control block
`timescale 1ns/10ps
`include "mpfc_map.svh"
module mpfc_top_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow, e;
  logic [7:0] paddr, frames;
  logic [31:0] pwdata, prdata, rd;
  logic [47:0] station_addr, rx_da;
  logic [15:0] rx_type, rx_opcode, rx_quanta, tx_pause_time, last_time;
  logic std_filter_pass, rx_hdr_valid, rx_frame_ok, rx_deliver_valid;
  logic rx_deliver, tx_paused, fifo_overflow, an_pause_resolved;
  logic ext_xoff_in, external_resume_input, tx_frame_active, tx_pause_req;
  logic tx_pause_done, above_high_mark_out, under_low_mark_out;
  logic asymmetric_pause_direction;
  logic [12:0] fifo_level;
  int n_mismatch, n_compared, nf, cyc;
  localparam logic [47:0] SA = 48'h0A1B2C3D4E5F;
  localparam logic [47:0] MC = `MPFC_CTL_MCAST;

  mpfc_top uut (.*);
  mpfc_mac_model partner (.pclk(pclk), .presetn(presetn), .slow(slow),
    .tx_pause_req(tx_pause_req), .tx_pause_time(tx_pause_time),
    .tx_pause_done(tx_pause_done), .frames(frames), .last_time(last_time));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // ==========================================
  // checking and reporting
  task automatic chk(input logic [31:0] got, exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic final_report;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  // hang guard, run needs under a thousand cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  // ==========================================
  // bus and stimulus tasks
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic do_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    nf = 0;
  endtask : do_reset
  task automatic frame_chk(input logic [15:0] t, input int add);
    int i;
    nf += add;
    for (i = 0; i < 100 && frames !== nf[7:0]; i++) @(posedge pclk);
    repeat (20) @(posedge pclk);
    chk(frames, nf, "frame count");
    if (add > 0) chk(last_time, t, "pause time");
  endtask : frame_chk
  task automatic lvl(input logic [12:0] v);
    @(posedge pclk);
    fifo_level <= v;
  endtask : lvl
  task automatic rx_case(input logic [31:0] c, input logic [47:0] da,
      input logic [15:0] ty, op, input logic std, exp);
    apb(`MPFC_CTRL_OFF, 1'b1, c);
    @(posedge pclk);
    {rx_hdr_valid, rx_da, rx_type, rx_opcode, std_filter_pass} <=
      {1'b1, da, ty, op, std};
    @(posedge pclk);
    rx_hdr_valid <= 1'b0;
    #1;
    chk(rx_deliver_valid, 1'b1, "decision strobe");
    chk(rx_deliver, exp, "deliver");
  endtask : rx_case
  // ==========================================
  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, rx_hdr_valid} <= '0;
    {fifo_overflow, ext_xoff_in, external_resume_input} <= '0;
    {tx_frame_active, an_pause_resolved, slow, rx_quanta} <= '0;
    {rx_da, rx_type, rx_opcode, std_filter_pass, fifo_level} <= '0;
    {presetn, rx_frame_ok, station_addr} <= {2'b01, SA};
    do_reset();
    apb(`MPFC_TYPE_OFF, 1'b0, 0);
    chk(rd, `MPFC_TYPE_RST, "type reset");
    apb(`MPFC_CTRL_OFF, 1'b0, 0);
    chk(rd, `MPFC_CTRL_RST, "ctrl reset");
    apb(`MPFC_STAT_OFF, 1'b0, 0);
    chk(rd, 32'h00000040, "status reset");
    apb(8'h18, 1'b0, 0);
    chk(e, 1'b1, "unmapped error");
    chk(rd, 32'h00000000, "unmapped read");
    rx_case(32'h04, SA, 16'h8808, 16'h0001, 1'b1, 1'b1);
    rx_case(32'h04, SA, 16'h8808, 16'h0001, 1'b0, 1'b0);
    rx_case(32'h05, SA, 16'h8808, 16'h0001, 1'b1, 1'b0);
    rx_case(32'h01, SA, 16'h8808, 16'h0001, 1'b1, 1'b1);
    rx_case(32'h05, MC, 16'h8808, 16'h0001, 1'b1, 1'b1);
    rx_case(32'h05, MC, 16'h8808, 16'h0001, 1'b0, 1'b0);
    rx_case(32'h09, SA, 16'h8808, 16'h0002, 1'b0, 1'b1);
    rx_case(32'h09, SA, 16'h8808, 16'h0001, 1'b0, 1'b0);
    rx_case(32'h01, SA, 16'h8808, 16'h0002, 1'b1, 1'b1);
    rx_case(32'h01, MC, 16'h8808, 16'h0002, 1'b0, 1'b0);
    rx_case(32'h05, SA, 16'h8809, 16'h0001, 1'b1, 1'b1);
    apb(`MPFC_TYPE_OFF, 1'b1, 32'h8809);
    rx_case(32'h05, SA, 16'h8809, 16'h0001, 1'b1, 1'b0);
    apb(`MPFC_TYPE_OFF, 1'b1, 32'h8808);
    rx_quanta <= 16'h0002;
    rx_case(32'h05, SA, 16'h8808, 16'h0001, 1'b1, 1'b0);
    // two slots of 26 cycles: still paused at 50, expired by 54
    repeat (50) @(posedge pclk);
    chk(tx_paused, 1'b1, "paused in second slot");
    repeat (4) @(posedge pclk);
    chk(tx_paused, 1'b0, "pause expired");
    // software request with transmit enable off and no negotiation
    slow <= 1'b1;
    apb(`MPFC_TIMER_OFF, 1'b1, 32'h1234);
    apb(`MPFC_CTRL_OFF, 1'b1, 32'h10);
    frame_chk(16'h1234, 1);
    apb(`MPFC_CTRL_OFF, 1'b0, 0);
    chk(rd[4], 1'b0, "request self-clear");
    slow <= 1'b0;
    apb(`MPFC_TIMER_OFF, 1'b1, 32'h0);
    apb(`MPFC_CTRL_OFF, 1'b1, 32'h10);
    frame_chk(16'h0000, 1);
    tx_frame_active <= 1'b1;
    apb(`MPFC_TIMER_OFF, 1'b1, 32'h40);
    apb(`MPFC_CTRL_OFF, 1'b1, 32'h10);
    repeat (20) @(posedge pclk);
    chk(tx_pause_req, 1'b0, "held during frame");
    tx_frame_active <= 1'b0;
    frame_chk(16'h0040, 1);
    // thresholds, link assumed full duplex
    apb(`MPFC_HIGH_OFF, 1'b1, 100);
    apb(`MPFC_LOW_OFF, 1'b1, 20);
    lvl(50);
    an_pause_resolved <= 1'b1;
    apb(`MPFC_CTRL_OFF, 1'b1, 32'h22);
    frame_chk(0, 0);
    chk(asymmetric_pause_direction, 1'b1, "config mirror");
    chk({above_high_mark_out, under_low_mark_out}, 0, "mid marks");
    lvl(100);
    frame_chk(16'h0040, 1);
    chk(above_high_mark_out, 1'b0, "at high");
    lvl(101);
    repeat (3) @(posedge pclk);
    chk(above_high_mark_out, 1'b1, "above high");
    apb(`MPFC_STAT_OFF, 1'b0, 0);
    chk(rd, 32'h000000C5, "status after xoff");
    lvl(10);
    frame_chk(16'h0000, 1);
    chk(under_low_mark_out, 1'b1, "under low");
    lvl(100);
    frame_chk(16'h0040, 1);
    @(posedge pclk) fifo_overflow <= 1'b1;
    @(posedge pclk) fifo_overflow <= 1'b0;
    frame_chk(16'h0040, 1);
    @(posedge pclk) fifo_overflow <= 1'b1;
    @(posedge pclk) fifo_overflow <= 1'b0;
    frame_chk(0, 0);
    lvl(10);
    frame_chk(16'h0000, 1);
    apb(`MPFC_CTRL_OFF, 1'b1, 32'h02);
    lvl(100);
    frame_chk(16'h0040, 1);
    lvl(10);
    frame_chk(0, 0);
    apb(`MPFC_CTRL_OFF, 1'b1, 32'h22);
    an_pause_resolved <= 1'b0;
    lvl(100);
    frame_chk(0, 0);
    // external pins, second reset in mid-run
    do_reset();
    apb(`MPFC_TIMER_OFF, 1'b1, 32'h77);
    apb(`MPFC_HIGH_OFF, 1'b1, 100);
    apb(`MPFC_LOW_OFF, 1'b1, 20);
    lvl(50);
    an_pause_resolved <= 1'b1;
    apb(`MPFC_CTRL_OFF, 1'b1, 32'h62);
    @(posedge pclk) ext_xoff_in <= 1'b1;
    frame_chk(16'h0077, 1);
    frame_chk(0, 0);
    @(posedge pclk) ext_xoff_in <= 1'b0;
    @(posedge pclk) ext_xoff_in <= 1'b1;
    frame_chk(0, 0);
    @(posedge pclk) ext_xoff_in <= 1'b0;
    @(posedge pclk) external_resume_input <= 1'b1;
    frame_chk(16'h0000, 1);
    @(posedge pclk) external_resume_input <= 1'b0;
    @(posedge pclk) ext_xoff_in <= 1'b1;
    frame_chk(16'h0077, 1);
    @(posedge pclk) ext_xoff_in <= 1'b0;
    @(posedge pclk) external_resume_input <= 1'b1;
    frame_chk(16'h0000, 1);
    @(posedge pclk) external_resume_input <= 1'b0;
    apb(`MPFC_CTRL_OFF, 1'b1, 32'h60);
    @(posedge pclk) ext_xoff_in <= 1'b1;
    frame_chk(0, 0);
    final_report();
  end
endmodule : mpfc_top_tb
